// ---- cbit_reset_consts.svh ----
// Offsets, field positions and reset values of the channel-status and reset/sleep control registers
`ifndef CBIT_RESET_CONSTS_SVH
`define CBIT_RESET_CONSTS_SVH

`define CSTAT_CTRL_OFFSET 12'h00e
`define RSC_CTRL_OFFSET 12'h00f
`define CSTAT_CTRL_RESET 8'h00
`define RSC_CTRL_RESET 8'h00
`define CSTAT_RSVD_MASK 8'h7f
`define BIT_ACC0 0
`define BIT_ACC1 1
`define BIT_SRC_LO 2
`define BIT_SRC_HI 5
`define BIT_TAP 6
`define BIT_SOFT_RESET_BIT 0
`define BIT_HELD_CHIP_RESET_BIT 1
`define BIT_SLP 2
`define BIT_DIGOUT_DISABLE 3
`define BIT_XTAL_SYSCLK_OUT_DISABLE 4
`define BIT_MASTER_CLK_OUT_DISABLE 5
`define BIT_SYS_CLK_OUT_DISABLE 6
`define BIT_APC 7
`define CS_ACC_LO 28
`define CS_SRC_LO 16
`define CS_WIDTH 32
`define ACC_PROHIBITED 2'h3

`endif

// ---- cbit_reset_pkg.sv ----
// Types shared by the control register bank
package cbit_reset_pkg;

  typedef struct packed {
    logic [11:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
  } apb_req_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } apb_rsp_s;

  typedef struct packed {
    logic digout_disable;
    logic xtal_sysclk_out_disable;
    logic master_clk_out_disable;
    logic sys_clk_out_disable;
  } pin_dis_s;

  typedef enum logic [2:0] {
    RST_RUN = 3'b001,
    RST_SOFT = 3'b010,
    RST_HELD = 3'b100
  } rst_state_e;

endpackage : cbit_reset_pkg

// ---- cbit_reset_regs.sv ----
// Channel-status and reset/sleep/clock-out control registers behind an APB slave
//
// Summary of operation
// - Accuracy bits go to channel-status bits 28,29
// - Source number goes to channel-status bits 16-19
// - Tap select picks before or after channel control
// - Soft reset loads defaults then self-clears
// - Held reset keeps chip reset until cleared
// - Sleep ends only by external or held reset
// - Sleep bit leaves analog circuits untouched
// - Digital-out disable holds pin low
// - Crystal sysclk disable holds pin low
// - Master clock disable holds pin low
// - System clock disable holds pin low
// - Phase control enable counts only with PLL select
`timescale 1ns/1ps
`include "cbit_reset_consts.svh"

module cbit_reset_regs
(
  // Clock and reset
  input wire logic CLK,
  input wire logic NRST,
  // APB slave
  input wire cbit_reset_pkg::apb_req_s APB_REQ,
  output cbit_reset_pkg::apb_rsp_s APB_RSP,
  // Audio data streams, clock sources and PLL select
  input wire logic DIGOUT_AFTER_CTRL,
  input wire logic DIGOUT_BEFORE_CTRL,
  input wire logic XTAL_SYSCLK,
  input wire logic MASTER_CLK,
  input wire logic SYS_CLK,
  input wire logic PLL_CLOCK_SELECT,
  // Channel status and control outputs
  output logic [31:0] CHANNEL_STATUS,
  output logic DIGOUT_SRC,
  output logic CHIP_RESET,
  output logic DIGITAL_SLEEP,
  output logic PHASE_CTRL_ACTIVE,
  // Pins
  output logic DIGOUT_PIN,
  output logic XTAL_SYSCLK_PIN,
  output logic MASTER_CLK_PIN,
  output logic SYS_CLK_PIN
);

  import cbit_reset_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode

  logic wr_en;
  logic rd_access;
  logic hit_cstat;
  logic hit_rsc;

  // Each register holds one aligned word: byte address is four times its index
  always_comb
  begin
    hit_rsc = (APB_REQ.paddr == (`RSC_CTRL_OFFSET << 2));
    hit_cstat = (APB_REQ.paddr == (`CSTAT_CTRL_OFFSET << 2));
    wr_en = APB_REQ.psel && APB_REQ.penable && APB_REQ.pwrite;
    rd_access = APB_REQ.psel && APB_REQ.penable && !APB_REQ.pwrite;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register state

  logic [7:0] cstat_reg;
  logic [7:0] cstat_next;
  logic [7:0] rsc_reg;
  logic [7:0] rsc_next;
  logic sleep_reg;
  logic sleep_next;
  rst_state_e rst_state_reg;
  rst_state_e rst_state_next;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;

  always_comb
  begin
    cstat_next = cstat_reg;
    rsc_next = rsc_reg;
    sleep_next = sleep_reg;
    rst_state_next = rst_state_reg;
    case (rst_state_reg)
      RST_RUN:
      begin
        if (wr_en && hit_cstat)
          cstat_next = APB_REQ.pwdata[7:0] & `CSTAT_RSVD_MASK;
        if (wr_en && hit_rsc)
        begin
          rsc_next = APB_REQ.pwdata[7:0];
          if (APB_REQ.pwdata[`BIT_SLP])
            sleep_next = 1'b1;
          if (APB_REQ.pwdata[`BIT_HELD_CHIP_RESET_BIT])
            rst_state_next = RST_HELD;
          else if (APB_REQ.pwdata[`BIT_SOFT_RESET_BIT])
            rst_state_next = RST_SOFT;
        end
      end
      RST_SOFT:
      begin
        cstat_next = `CSTAT_CTRL_RESET;
        rsc_next = `RSC_CTRL_RESET;
        rst_state_next = RST_RUN;
      end
      RST_HELD:
      begin
        cstat_next = `CSTAT_CTRL_RESET;
        rsc_next = `RSC_CTRL_RESET;
        rsc_next[`BIT_HELD_CHIP_RESET_BIT] = 1'b1;
        sleep_next = 1'b0;
        if (wr_en && hit_rsc && !APB_REQ.pwdata[`BIT_HELD_CHIP_RESET_BIT])
        begin
          rsc_next = `RSC_CTRL_RESET;
          rst_state_next = RST_RUN;
        end
      end
      default:
      begin
        rst_state_next = RST_RUN;
      end
    endcase
    prdata_next = prdata_reg;
    if (rd_access)
      prdata_next = hit_cstat ? {24'h000000, cstat_reg} : (hit_rsc ? {24'h000000, rsc_reg} : 32'h00000000);
  end

  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      cstat_reg <= `CSTAT_CTRL_RESET;
      rsc_reg <= `RSC_CTRL_RESET;
      sleep_reg <= 1'b0;
      rst_state_reg <= RST_RUN;
      prdata_reg <= 32'h00000000;
    end
    else
    begin
      cstat_reg <= cstat_next;
      rsc_reg <= rsc_next;
      sleep_reg <= sleep_next;
      rst_state_reg <= rst_state_next;
      prdata_reg <= prdata_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus answer: one wait state on reads, writes complete at once

  logic rd_wait_reg;
  logic rd_wait_next;

  always_comb
  begin
    rd_wait_next = rd_access && !rd_wait_reg;
  end

  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
      rd_wait_reg <= 1'b0;
    else
      rd_wait_reg <= rd_wait_next;
  end

  always_comb
  begin
    APB_RSP.pready = APB_REQ.pwrite ? 1'b1 : rd_wait_reg;
    APB_RSP.pslverr = APB_REQ.psel && APB_REQ.penable && !(hit_cstat || hit_rsc);
    APB_RSP.prdata = prdata_reg;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Channel status and control outputs

  logic [31:0] cs_reg;
  logic [31:0] cs_next;
  logic src_reg;
  logic src_next;
  logic apc_reg;
  logic apc_next;

  always_comb
  begin
    cs_next = 32'h00000000;
    cs_next[`CS_ACC_LO +: 2] = cstat_reg[`BIT_ACC1:`BIT_ACC0];
    cs_next[`CS_SRC_LO +: 4] = cstat_reg[`BIT_SRC_HI:`BIT_SRC_LO];
    src_next = cstat_reg[`BIT_TAP] ? DIGOUT_BEFORE_CTRL : DIGOUT_AFTER_CTRL;
    apc_next = PLL_CLOCK_SELECT && rsc_reg[`BIT_APC];
  end

  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      cs_reg <= 32'h00000000;
      src_reg <= 1'b0;
      apc_reg <= 1'b0;
    end
    else
    begin
      cs_reg <= cs_next;
      src_reg <= src_next;
      apc_reg <= apc_next;
    end
  end

  assign CHANNEL_STATUS = cs_reg;
  assign DIGOUT_SRC = src_reg;
  assign PHASE_CTRL_ACTIVE = apc_reg;
  assign CHIP_RESET = (rst_state_reg != RST_RUN);
  assign DIGITAL_SLEEP = sleep_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Pin gating

  pin_dis_s dis;
  logic [3:0] pins;

  always_comb
  begin
    dis.digout_disable = rsc_reg[`BIT_DIGOUT_DISABLE];
    dis.xtal_sysclk_out_disable = rsc_reg[`BIT_XTAL_SYSCLK_OUT_DISABLE];
    dis.master_clk_out_disable = rsc_reg[`BIT_MASTER_CLK_OUT_DISABLE];
    dis.sys_clk_out_disable = rsc_reg[`BIT_SYS_CLK_OUT_DISABLE];
  end

  pin_gate u_pin_gate
  (
    .CLK(CLK),
    .NRST(NRST),
    .src({src_reg, XTAL_SYSCLK, MASTER_CLK, SYS_CLK}),
    .dis({dis.digout_disable, dis.xtal_sysclk_out_disable, dis.master_clk_out_disable, dis.sys_clk_out_disable}),
    .pins(pins)
  );

  assign DIGOUT_PIN = pins[3];
  assign XTAL_SYSCLK_PIN = pins[2];
  assign MASTER_CLK_PIN = pins[1];
  assign SYS_CLK_PIN = pins[0];

endmodule : cbit_reset_regs

// ---- cbit_reset_regs_chk.sv ----
// Concurrent checks on the control register bank ports
`timescale 1ns/1ps
module cbit_reset_chk
(
  // Clock, reset and bus
  input wire logic CLK,
  input wire logic NRST,
  input wire cbit_reset_pkg::apb_req_s APB_REQ,
  input wire cbit_reset_pkg::apb_rsp_s APB_RSP,
  // Sources
  input wire logic XTAL_SYSCLK,
  input wire logic MASTER_CLK,
  input wire logic SYS_CLK,
  input wire logic PLL_CLOCK_SELECT,
  // Outputs
  input wire logic [31:0] CHANNEL_STATUS,
  input wire logic CHIP_RESET,
  input wire logic DIGITAL_SLEEP,
  input wire logic PHASE_CTRL_ACTIVE,
  input wire logic XTAL_SYSCLK_PIN,
  input wire logic MASTER_CLK_PIN,
  input wire logic SYS_CLK_PIN
);
  import cbit_reset_pkg::*;
  default clocking @(posedge CLK);
  endclocking
  default disable iff (!NRST);
  wire acc = APB_REQ.psel & APB_REQ.penable & APB_RSP.pready;
  wire wr = acc & APB_REQ.pwrite & !CHIP_RESET;
  wire we = wr & (APB_REQ.paddr == 12'h038);
  wire wf = wr & (APB_REQ.paddr == 12'h03c);
  property p_acc; we |-> ##2 CHANNEL_STATUS[29:28] == $past(APB_REQ.pwdata[1:0], 2); endproperty
  a_acc: assert property (p_acc) else $error("accuracy field mismatch");
  property p_src; we |-> ##2 CHANNEL_STATUS[19:16] == $past(APB_REQ.pwdata[5:2], 2); endproperty
  a_src: assert property (p_src) else $error("source field mismatch");
  property p_apc; PHASE_CTRL_ACTIVE |-> $past(PLL_CLOCK_SELECT); endproperty
  a_apc: assert property (p_apc) else $error("phase control without pll select");
  property p_pins; ({XTAL_SYSCLK_PIN, MASTER_CLK_PIN, SYS_CLK_PIN} & ~$past({XTAL_SYSCLK, MASTER_CLK, SYS_CLK})) == 0;
  endproperty
  a_pins: assert property (p_pins) else $error("clock pin high without source");
  property p_soft_reset_bit; wf && APB_REQ.pwdata[1:0] == 2'h1 |=> CHIP_RESET ##1 !CHIP_RESET; endproperty
  a_soft_reset_bit: assert property (p_soft_reset_bit) else $error("soft reset not one cycle");
  property p_held_chip_reset_bit; wf && APB_REQ.pwdata[1] |=> CHIP_RESET [*2]; endproperty
  a_held_chip_reset_bit: assert property (p_held_chip_reset_bit) else $error("held reset not held");
  property p_slp; $fell(DIGITAL_SLEEP) |-> CHIP_RESET || $past(CHIP_RESET); endproperty
  a_slp: assert property (p_slp) else $error("sleep left without reset");
  property p_rsv; acc && !APB_REQ.pwrite && APB_REQ.paddr == 12'h038 |-> APB_RSP.prdata[31:7] == 0; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits read nonzero");
  c_soft_reset_bit: cover property (wf && APB_REQ.pwdata[0]);
  c_slp: cover property ($fell(DIGITAL_SLEEP));
  c_err: cover property (acc && APB_RSP.pslverr);
endmodule : cbit_reset_chk

bind cbit_reset_regs cbit_reset_chk chk_u (.*);

// ---- pin_gate.sv ----
// Output pin gating: each pin follows its source or is held low when disabled
`timescale 1ns/1ps
`include "cbit_reset_consts.svh"

module pin_gate
(
  // Clock and reset
  input wire logic CLK,
  input wire logic NRST,
  // Sources and disables
  input wire logic [3:0] src,
  input wire logic [3:0] dis,
  // Gated pins
  output logic [3:0] pins
);

  logic [3:0] pins_reg;
  logic [3:0] pins_next;

  genvar i;
  generate
    for (i = 0; i < 4; i = i + 1)
    begin : g_pin
      always_comb
      begin
        pins_next[i] = dis[i] ? 1'b0 : src[i];
      end
    end
  endgenerate

  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
      pins_reg <= 4'h0;
    else
      pins_reg <= pins_next;
  end

  assign pins = pins_reg;

endmodule : pin_gate

// ---- tb_cbit_reset_regs.sv ----
// Register-level tests of the channel-status and reset/sleep control bank
`timescale 1ns/1ps
module tb_cbit_reset_regs;
  import cbit_reset_pkg::*;
  logic CLK = 0;
  logic NRST = 0;
  apb_req_s APB_REQ = '0;
  apb_rsp_s APB_RSP;
  logic DIGOUT_AFTER_CTRL = 0, DIGOUT_BEFORE_CTRL = 1, XTAL_SYSCLK = 1, MASTER_CLK = 1, SYS_CLK = 1;
  logic PLL_CLOCK_SELECT = 0;
  logic [31:0] CHANNEL_STATUS;
  logic DIGOUT_SRC, CHIP_RESET, DIGITAL_SLEEP, PHASE_CTRL_ACTIVE;
  logic DIGOUT_PIN, XTAL_SYSCLK_PIN, MASTER_CLK_PIN, SYS_CLK_PIN;
  int err_count = 0;
  int checks_done = 0;
  logic [31:0] rd;
  logic se;
  cbit_reset_regs dut_u (.*);
  always #50 CLK = ~CLK;
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] wd);
    @(posedge CLK);
    APB_REQ <= '{a, 1'b1, 1'b0, w, wd};
    @(posedge CLK);
    APB_REQ.penable <= 1;
    // Look at the settled answer before the edge at which it is taken
    @(negedge CLK);
    while (APB_RSP.pready !== 1'b1) @(negedge CLK);
    rd = APB_RSP.prdata;
    se = APB_RSP.pslverr;
    @(posedge CLK);
    APB_REQ.psel <= 0;
    APB_REQ.penable <= 0;
  endtask : xfer
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      $display("[ERR] %s exp %h got %h", n, e, g);
      err_count++;
    end
  endtask : chk
  task automatic rchk(input string n, input logic [11:0] a, input logic [31:0] e);
    xfer(0, a, 0);
    chk(n, e, rd);
  endtask : rchk
  task automatic complete_run;
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : complete_run
  ////////////////////////////////////////////////////////////
  initial
  begin
    repeat (2000) @(posedge CLK);
    err_count++;
    complete_run();
  end
  initial
  begin
    repeat (20) @(posedge CLK);
    NRST <= 1;
    rchk("cs_rd", 12'h038, 0);
    rchk("rsc_rd", 12'h03c, 0);
    $display("test defaults done");
    for (int i = 0; i < 3; i++)
    begin
      xfer(1, 12'h038, 32'h80 | i | (i * 7 + 1) << 2);
      repeat (3) @(posedge CLK);
      chk("cstat", (i << 28) | ((i * 7 + 1) << 16), CHANNEL_STATUS);
      rchk("cs_rb", 12'h038, i | (i * 7 + 1) << 2);
    end
    $display("test status done");
    xfer(1, 12'h038, 32'h40);
    repeat (3) @(posedge CLK);
    chk("tap1", 3, {DIGOUT_SRC, DIGOUT_PIN});
    xfer(1, 12'h038, 0);
    repeat (3) @(posedge CLK);
    chk("tap0", 0, {DIGOUT_SRC, DIGOUT_PIN});
    $display("test tap done");
    DIGOUT_AFTER_CTRL <= 1;
    for (int i = 0; i < 4; i++)
    begin
      xfer(1, 12'h03c, 32'h8 << i);
      repeat (3) @(posedge CLK);
      chk("pins", 4'hf & ~(4'h8 >> i), {DIGOUT_PIN, XTAL_SYSCLK_PIN, MASTER_CLK_PIN, SYS_CLK_PIN});
    end
    $display("test pins done");
    xfer(1, 12'h03c, 32'h80);
    repeat (2) @(posedge CLK);
    chk("apc0", 0, PHASE_CTRL_ACTIVE);
    PLL_CLOCK_SELECT <= 1;
    repeat (3) @(posedge CLK);
    chk("apc1", 1, PHASE_CTRL_ACTIVE);
    $display("test phase done");
    xfer(1, 12'h038, 32'h3d);
    xfer(1, 12'h03c, 32'h01);
    repeat (2) @(posedge CLK);
    rchk("soft_reset_bit_e", 12'h038, 0);
    rchk("soft_reset_bit_f", 12'h03c, 0);
    $display("test soft reset done");
    xfer(1, 12'h03c, 32'h04);
    repeat (3) @(posedge CLK);
    chk("sleep", 1, DIGITAL_SLEEP);
    xfer(1, 12'h03c, 32'h02);
    xfer(1, 12'h038, 32'h3f);
    repeat (3) @(posedge CLK);
    chk("held", 1, CHIP_RESET);
    xfer(1, 12'h03c, 0);
    repeat (3) @(posedge CLK);
    chk("wake", 0, {CHIP_RESET, DIGITAL_SLEEP});
    rchk("held_e", 12'h038, 0);
    $display("test held reset done");
    xfer(0, 12'h040, 0);
    chk("unmapped", 1, {rd[30:0], se});
    $display("test unmapped done");
    complete_run();
  end
endmodule : tb_cbit_reset_regs
